// >>> design/mdp_pkg.sv
// Constants, comparator bundle and drive types for the motor protection supervisor
package mdp_pkg;

	// Clock and protection timing, each time in its own unit
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned OCL_BLANK_NS    = 2300;
	localparam int unsigned OCP_BLANK_NS    = 800;
	localparam int unsigned OCP_HOLD_MS     = 15;
	localparam int unsigned STALL_DETECT_S  = 5;
	localparam int unsigned STALL_HOLD_S    = 64;
	localparam int unsigned NS_PER_MS       = 1_000_000;
	localparam int unsigned NS_PER_S        = 1_000_000_000;

	// Least times round up to whole cycles
	localparam int unsigned OCL_BLANK_CYC   = (OCL_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OCP_BLANK_CYC   = (OCP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OCP_HOLD_CYC    = OCP_HOLD_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned STALL_DETECT_CYC = STALL_DETECT_S * (NS_PER_S / CLK_PERIOD_NS);
	localparam int unsigned STALL_HOLD_CYC  = STALL_HOLD_S * (NS_PER_S / CLK_PERIOD_NS);

	// APB register map
	localparam int unsigned APB_ADDR_W      = 8;
	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  STATUS_OFS      = 8'h04;
	localparam logic [7:0]  POS_OFS         = 8'h08;

	// Control register fields and reset value
	localparam int unsigned CTRL_STALL_EN   = 0;
	localparam int unsigned CTRL_DRIVE_EN   = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h3;

	// Status register fields
	localparam int unsigned ST_REG_LOCK     = 0;
	localparam int unsigned ST_BOOT_LOCK    = 1;
	localparam int unsigned ST_GATE_LOCK    = 4;
	localparam int unsigned ST_CLIMIT       = 5;
	localparam int unsigned ST_OCP          = 6;
	localparam int unsigned ST_TSD          = 7;
	localparam int unsigned ST_STALL        = 8;
	localparam int unsigned ST_HALL_BAD     = 9;
	localparam int unsigned ST_OPPOSITE     = 10;
	localparam int unsigned ST_FAULT        = 11;

	// Position register fields
	localparam int unsigned POS_CODE        = 0;
	localparam int unsigned POS_REV_ROT     = 3;

	// Comparator indications, all synchronised together
	typedef struct packed {
		logic       reg_low;
		logic       reg_ok;
		logic [2:0] boot_low;
		logic [2:0] boot_ok;
		logic       gate_low;
		logic       gate_ok;
		logic       lim;
		logic       trip;
		logic       open;
		logic       hot;
		logic       cool;
		logic [2:0] pos;
	} mdp_cmp_t;

	typedef enum logic {DRV_SINE, DRV_TRAP} mdp_drive_t;

endpackage : mdp_pkg

// >>> design/mdp_tmr_if.sv
// Run and done pair between the supervisor and one of its cycle timers
interface mdp_tmr_if;
	logic run;
	logic done;
	modport ctl (output run, input done);
	modport tmr (input run, output done);
endinterface : mdp_tmr_if

// >>> design/mdp_timer.sv
// Cycle counter that flags when its run level has stood for LIMIT cycles
module mdp_timer #(
	parameter int unsigned LIMIT = 1
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	mdp_tmr_if.tmr    tmr
);
	localparam logic [31:0] LAST = 32'(LIMIT - 1);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	if (LIMIT < 1) begin : g_chk
		$error("mdp_timer: LIMIT must be at least one");
	end

	// Counts while run is high, saturates at the last step, restarts when run drops
	assign tmr.done = tmr.run && (cnt_q == LAST);
	assign cnt_d    = !tmr.run ? 32'h0 : (cnt_q == LAST) ? cnt_q : cnt_q + 32'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : mdp_timer

// >>> design/mdp_supervisor.sv
// Protection and fault supervisor for a three-phase inverter gate driver
// Behaviour
// - Regulator supply low shuts all gates off, raises fault; release on ok.
// - Bootstrap supply low shuts high sides only until supply recovers.
// - Gate supply low shuts all gates off until supply recovers.
// - Shunt over limit for full blanking time shuts all gates off.
// - Current limit shutdown clears at each PWM cycle start.
// - Shunt over trip level for its blanking time enters overcurrent protection.
// - Overcurrent protection holds gates off, fault high, for fixed hold time.
// - Open shunt input counts as overcurrent and trips protection.
// - Over temperature shuts all gates off and raises fault.
// - Thermal shutdown releases only once temperature falls by hysteresis.
// - Position unchanged for lock detect time starts stall guard.
// - Stall guard holds gates off, fault high, for its hold time.
// - Fault high while rotation opposes selected direction; when it agrees, fault is low unless another protection is active.
// - Rotation opposite to direction select switches to trapezoidal drive within one step.
// - Drive type follows direction select versus actual rotation.
// - All position signals equal flags abnormality, shuts all gates off.
// - Fault high during abnormality; valid codes follow commutation tables.
// - Fault output low when no protection is active.
// - Forward code H-L-H drives U low side and V high side.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module mdp_supervisor
	import mdp_pkg::*;
#(
	parameter int unsigned OCL_BLANK   = OCL_BLANK_CYC,
	parameter int unsigned OCP_BLANK   = OCP_BLANK_CYC,
	parameter int unsigned OCP_HOLD    = OCP_HOLD_CYC,
	parameter int unsigned STALL_DET   = STALL_DETECT_CYC,
	parameter int unsigned STALL_HOLD  = STALL_HOLD_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [APB_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  reg_supply_low_i,
	input  wire logic                  reg_supply_ok_i,
	input  wire logic [2:0]            bootstrap_supply_low_i,
	input  wire logic [2:0]            bootstrap_supply_ok_i,
	input  wire logic                  gate_supply_low_i,
	input  wire logic                  gate_supply_ok_i,
	input  wire logic                  shunt_limit_i,
	input  wire logic                  shunt_trip_i,
	input  wire logic                  shunt_open_i,
	input  wire logic                  die_hot_i,
	input  wire logic                  die_cool_i,
	input  wire logic                  pos_sense_u_i,
	input  wire logic                  pos_sense_v_i,
	input  wire logic                  pos_sense_w_i,
	input  wire logic                  direction_select_i,
	input  wire logic                  pwm_cycle_start_i,
	input  wire logic [2:0]            sine_gate_hi_i,
	input  wire logic [2:0]            sine_gate_lo_i,
	output logic      [2:0]            gate_hi_o,
	output logic      [2:0]            gate_lo_o,
	output logic                       fault_out_o,
	output logic                       trap_mode_o
);
	if (OCL_BLANK < 1 || OCP_BLANK < 1 || OCP_HOLD < 1
	    || STALL_DET < 1 || STALL_HOLD < 1) begin : g_chk
		$error("mdp_supervisor: every cycle count must be at least one");
	end

	// Forward six-step table, result is {hi U,V,W, lo U,V,W}
	function automatic logic [5:0] trap_fwd(input logic [2:0] c);
		case (c)
			3'b101:  trap_fwd = 6'b010_100;
			3'b100:  trap_fwd = 6'b001_100;
			3'b110:  trap_fwd = 6'b001_010;
			3'b010:  trap_fwd = 6'b100_010;
			3'b011:  trap_fwd = 6'b100_001;
			3'b001:  trap_fwd = 6'b010_001;
			default: trap_fwd = 6'b000_000;
		endcase
	endfunction : trap_fwd

	// Position code that follows c in forward rotation
	function automatic logic [2:0] fwd_next(input logic [2:0] c);
		case (c)
			3'b101:  fwd_next = 3'b100;
			3'b100:  fwd_next = 3'b110;
			3'b110:  fwd_next = 3'b010;
			3'b010:  fwd_next = 3'b011;
			3'b011:  fwd_next = 3'b001;
			3'b001:  fwd_next = 3'b101;
			default: fwd_next = 3'b000;
		endcase
	endfunction : fwd_next

	mdp_cmp_t   cmp_raw;
	mdp_cmp_t   cmp_s1_q;
	mdp_cmp_t   cmp_s2_q;
	logic       reg_lock_q;
	logic       reg_lock_d;
	logic [2:0] boot_lock_q;
	logic [2:0] boot_lock_d;
	logic       gate_lock_q;
	logic       gate_lock_d;
	logic       climit_q;
	logic       climit_d;
	logic       ocp_q;
	logic       ocp_d;
	logic       tsd_q;
	logic       tsd_d;
	logic       stall_q;
	logic       stall_d;
	logic [2:0] prev_pos_q;
	logic       rev_rot_q;
	logic       rev_rot_d;
	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic       hall_bad;
	logic       hall_step;
	logic       opposite;
	logic       all_off;
	logic       hi_off;
	logic       any_fault;
	logic [5:0] trap_gates;
	logic [2:0] drv_hi;
	logic [2:0] drv_lo;
	mdp_drive_t drive;
	logic       apb_setup;
	logic       apb_access;
	logic       sel_ctrl;
	logic       sel_status;
	logic       sel_pos;
	logic       unmapped;
	logic       ctrl_wr;
	logic [31:0] status_word;
	logic [31:0] rdata_d;

	mdp_tmr_if ocl_blank_if ();
	mdp_tmr_if ocp_blank_if ();
	mdp_tmr_if ocp_hold_if ();
	mdp_tmr_if stall_det_if ();
	mdp_tmr_if stall_hold_if ();

	// Comparator bundle gathered from the pins
	assign cmp_raw = '{reg_low: reg_supply_low_i, reg_ok: reg_supply_ok_i,
		boot_low: bootstrap_supply_low_i, boot_ok: bootstrap_supply_ok_i,
		gate_low: gate_supply_low_i, gate_ok: gate_supply_ok_i,
		lim: shunt_limit_i, trip: shunt_trip_i, open: shunt_open_i,
		hot: die_hot_i, cool: die_cool_i,
		pos: {pos_sense_u_i, pos_sense_v_i, pos_sense_w_i}};

	// Two-flop synchroniser per comparator bit
	for (genvar b = 0; b < $bits(mdp_cmp_t); b++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cmp_s1_q[b] <= 1'b0;
				cmp_s2_q[b] <= 1'b0;
			end else begin
				cmp_s1_q[b] <= cmp_raw[b];
				cmp_s2_q[b] <= cmp_s1_q[b];
			end
		end
	end

	// Cycle timers for blanking, hold and lock detection
	assign ocl_blank_if.run  = cmp_s2_q.lim;
	assign ocp_blank_if.run  = cmp_s2_q.trip;
	assign ocp_hold_if.run   = ocp_q;
	assign stall_det_if.run  = ctrl_q[CTRL_STALL_EN] && !stall_q && !hall_step;
	assign stall_hold_if.run = stall_q;

	mdp_timer #(.LIMIT(OCL_BLANK)) u_ocl_blank (
		.clk_i (clk_i), .rst_i (rst_i), .tmr (ocl_blank_if.tmr));
	mdp_timer #(.LIMIT(OCP_BLANK)) u_ocp_blank (
		.clk_i (clk_i), .rst_i (rst_i), .tmr (ocp_blank_if.tmr));
	mdp_timer #(.LIMIT(OCP_HOLD)) u_ocp_hold (
		.clk_i (clk_i), .rst_i (rst_i), .tmr (ocp_hold_if.tmr));
	mdp_timer #(.LIMIT(STALL_DET)) u_stall_det (
		.clk_i (clk_i), .rst_i (rst_i), .tmr (stall_det_if.tmr));
	mdp_timer #(.LIMIT(STALL_HOLD)) u_stall_hold (
		.clk_i (clk_i), .rst_i (rst_i), .tmr (stall_hold_if.tmr));

	// Protection latches; a set in the same cycle as its release wins
	assign reg_lock_d  = cmp_s2_q.reg_low || (reg_lock_q && !cmp_s2_q.reg_ok);
	assign boot_lock_d = cmp_s2_q.boot_low | (boot_lock_q & ~cmp_s2_q.boot_ok);
	assign gate_lock_d = cmp_s2_q.gate_low || (gate_lock_q && !cmp_s2_q.gate_ok);
	assign climit_d    = ocl_blank_if.done || (climit_q && !pwm_cycle_start_i);
	assign ocp_d       = ocp_blank_if.done || cmp_s2_q.open
	                     || (ocp_q && !ocp_hold_if.done);
	assign tsd_d       = cmp_s2_q.hot || (tsd_q && !cmp_s2_q.cool);
	assign stall_d     = stall_det_if.done || (stall_q && !stall_hold_if.done);

	// Position checks and rotation sense
	assign hall_bad  = (cmp_s2_q.pos == 3'b000) || (cmp_s2_q.pos == 3'b111);
	assign hall_step = cmp_s2_q.pos != prev_pos_q;
	assign rev_rot_d = (hall_step && !hall_bad && prev_pos_q != 3'b000 && prev_pos_q != 3'b111)
	                   ? (cmp_s2_q.pos != fwd_next(prev_pos_q)) : rev_rot_q;
	assign opposite  = rev_rot_q ^ direction_select_i;
	assign drive     = opposite ? DRV_TRAP : DRV_SINE;

	// Reverse table equals forward table on the inverted code
	assign trap_gates = trap_fwd(rev_rot_q ? ~cmp_s2_q.pos : cmp_s2_q.pos);

	// Gate and fault decisions
	assign all_off   = reg_lock_q || gate_lock_q || climit_q || ocp_q || tsd_q || stall_q
	                   || hall_bad || !ctrl_q[CTRL_DRIVE_EN];
	assign hi_off    = all_off || (|boot_lock_q);
	assign any_fault = reg_lock_q || ocp_q || tsd_q || stall_q || opposite || hall_bad;
	assign drv_hi    = hi_off ? 3'h0 : (drive == DRV_TRAP) ? trap_gates[5:3] : sine_gate_hi_i;
	assign drv_lo    = all_off ? 3'h0 : (drive == DRV_TRAP) ? trap_gates[2:0] : sine_gate_lo_i;

	// Protection state and registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_lock_q  <= 1'b0;
			boot_lock_q <= 3'h0;
			gate_lock_q <= 1'b0;
			climit_q    <= 1'b0;
			ocp_q       <= 1'b0;
			tsd_q       <= 1'b0;
			stall_q     <= 1'b0;
			prev_pos_q  <= 3'h0;
			rev_rot_q   <= 1'b0;
			gate_hi_o   <= 3'h0;
			gate_lo_o   <= 3'h0;
			fault_out_o <= 1'b0;
			trap_mode_o <= 1'b0;
		end else begin
			reg_lock_q  <= reg_lock_d;
			boot_lock_q <= boot_lock_d;
			gate_lock_q <= gate_lock_d;
			climit_q    <= climit_d;
			ocp_q       <= ocp_d;
			tsd_q       <= tsd_d;
			stall_q     <= stall_d;
			prev_pos_q  <= cmp_s2_q.pos;
			rev_rot_q   <= rev_rot_d;
			gate_hi_o   <= drv_hi;
			gate_lo_o   <= drv_lo;
			fault_out_o <= any_fault;
			trap_mode_o <= (drive == DRV_TRAP);
		end
	end

	// APB decode; one wait-free access phase
	assign apb_setup   = psel_i && !penable_i;
	assign apb_access  = psel_i && penable_i && pready_o;
	assign sel_ctrl    = paddr_i == CTRL_OFS;
	assign sel_status  = paddr_i == STATUS_OFS;
	assign sel_pos     = paddr_i == POS_OFS;
	assign unmapped    = !(sel_ctrl || sel_status || sel_pos);
	assign ctrl_wr     = apb_access && pwrite_i && sel_ctrl;
	assign ctrl_d      = ctrl_wr ? pwdata_i[1:0] : ctrl_q;

	// Status word shows the live protection state
	always_comb begin
		status_word                 = 32'h0;
		status_word[ST_REG_LOCK]    = reg_lock_q;
		status_word[ST_BOOT_LOCK +: 3] = boot_lock_q;
		status_word[ST_GATE_LOCK]   = gate_lock_q;
		status_word[ST_CLIMIT]      = climit_q;
		status_word[ST_OCP]         = ocp_q;
		status_word[ST_TSD]         = tsd_q;
		status_word[ST_STALL]       = stall_q;
		status_word[ST_HALL_BAD]    = hall_bad;
		status_word[ST_OPPOSITE]    = opposite;
		status_word[ST_FAULT]       = fault_out_o;
	end

	// Read data mux
	assign rdata_d = sel_ctrl ? {30'h0, ctrl_q}
	               : sel_status ? status_word
	               : sel_pos ? {28'h0, rev_rot_q, cmp_s2_q.pos}
	               : 32'h0;

	// APB answer registers and control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= CTRL_RESET;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0;
		end else begin
			ctrl_q    <= ctrl_d;
			pready_o  <= apb_setup;
			pslverr_o <= apb_setup && unmapped;
			prdata_o  <= (apb_setup && !pwrite_i) ? rdata_d : 32'h0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Protection checks, one group of lines per guarded rule
	AST_REG_LOCK_OFF: assert property (reg_lock_q
		|=> (gate_hi_o == 3'h0 && gate_lo_o == 3'h0 && fault_out_o))
		else $error("regulator lockout left gates on");
	AST_BOOT_HI_OFF: assert property ((|boot_lock_q)
		|=> gate_hi_o == 3'h0)
		else $error("bootstrap lockout left a high side on");
	AST_GATE_LOCK_OFF: assert property (gate_lock_q
		|=> (gate_hi_o == 3'h0 && gate_lo_o == 3'h0))
		else $error("gate supply lockout left gates on");
	AST_OCL_SET: assert property ($rose(climit_q)
		|-> $past(cmp_s2_q.lim, 1) && $past(ocl_blank_if.done))
		else $error("current limit set without blanking");
	AST_OCL_CLEAR: assert property (climit_q && pwm_cycle_start_i
		&& !ocl_blank_if.done |=> !climit_q)
		else $error("current limit not cleared at cycle start");
	AST_OCP_ENTRY: assert property (ocp_blank_if.done
		|=> ocp_q ##1 fault_out_o)
		else $error("overcurrent blanking did not trip");
	AST_OCP_HOLD: assert property ($fell(ocp_q)
		|-> $past(ocp_hold_if.done) || $past(rst_i))
		else $error("overcurrent hold ended early");
	AST_OPEN_SHUNT: assert property (cmp_s2_q.open
		|=> ocp_q)
		else $error("open shunt did not trip");
	AST_TSD: assert property (tsd_q
		|=> fault_out_o && gate_lo_o == 3'h0)
		else $error("thermal shutdown left gates on");
	AST_TSD_HOLD: assert property (tsd_q && !cmp_s2_q.cool
		|=> tsd_q)
		else $error("thermal shutdown released before cooling");
	AST_STALL_ENTRY: assert property (stall_det_if.done
		|=> stall_q ##1 fault_out_o)
		else $error("stall guard did not start");
	AST_STALL: assert property (stall_det_if.done
		|=> stall_q [*2])
		else $error("stall guard not held");
	AST_REVERSE: assert property (opposite
		|=> trap_mode_o && fault_out_o)
		else $error("reverse rotation not handled");
	AST_DRIVE_SEL: assert property (!opposite
		|=> !trap_mode_o)
		else $error("trapezoidal drive without opposite rotation");
	AST_HALL_BAD: assert property (hall_bad
		|=> (fault_out_o && gate_hi_o == 3'h0 && gate_lo_o == 3'h0))
		else $error("position abnormality not handled");
	AST_SINE_FOLLOW: assert property (!hi_off && drive == DRV_SINE
		|=> gate_hi_o == $past(sine_gate_hi_i) && gate_lo_o == $past(sine_gate_lo_i))
		else $error("valid position code did not pass sine drive");
	AST_IDLE_LOW: assert property (!any_fault
		|=> !fault_out_o)
		else $error("fault output high with no protection");
	AST_TRAP_FWD: assert property (!hi_off && drive == DRV_TRAP && !rev_rot_q
		&& cmp_s2_q.pos == 3'b101 |=> gate_hi_o == 3'b010 && gate_lo_o == 3'b100)
		else $error("forward step table wrong for code 101");
	AST_SYNC_DELAY: assert property (!$past(rst_i) && !$past(rst_i, 2)
		|-> cmp_s2_q == $past(cmp_raw, 2))
		else $error("comparator synchroniser delay wrong");
endmodule : mdp_supervisor

// >>> sim/mdp_ctrl_model.sv
// Motor control microcontroller model that watches the fault output
module mdp_ctrl_model #(
	parameter int unsigned RESTART_WAIT = 10
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic fault_i,
	output logic      run_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int unsigned wait_q;

	// Stop at once on a fault; restart only after the quiet wait has run out
	always_ff @(posedge clk_i) begin
		if (rst_i || fault_i) begin
			run_o  <= 1'h0;
			wait_q <= 0;
		end else if (wait_q < RESTART_WAIT) begin
			wait_q <= wait_q + 1;
		end else begin
			run_o <= 1'h1;
		end
	end
endmodule : mdp_ctrl_model

// >>> sim/mdp_supervisor_bench.sv
// Self-checking bench for the motor protection supervisor
module mdp_supervisor_bench;
	import mdp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned OCPH = 40;
	localparam int unsigned STD  = 40;
	localparam int unsigned STH  = 30;
	localparam logic [2:0]  SHI  = 3'h4;
	localparam logic [2:0]  SLO  = 3'h3;

	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0, pready, pslverr, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  lows = 4'h0, oks = 4'hf;
	logic [2:0]  pos = 3'h5, ghi, glo;
	logic        lim = 1'h0, trip = 1'h0, open = 1'h0, dir = 1'h0, pwm = 1'h0;
	logic        fault, trap, run;
	int          miscompares = 0, n_tests = 0;

	// Clock at 100 ns
	always #50 clk_i = ~clk_i;

	mdp_supervisor #(.OCP_HOLD(OCPH), .STALL_DET(STD), .STALL_HOLD(STH)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .reg_supply_low_i(lows[0]), .reg_supply_ok_i(oks[0]),
		.bootstrap_supply_low_i({1'h0, lows[1], 1'h0}),
		.bootstrap_supply_ok_i({1'h1, oks[1], 1'h1}),
		.gate_supply_low_i(lows[2]), .gate_supply_ok_i(oks[2]), .shunt_limit_i(lim),
		.shunt_trip_i(trip), .shunt_open_i(open), .die_hot_i(lows[3]), .die_cool_i(oks[3]),
		.pos_sense_u_i(pos[2]), .pos_sense_v_i(pos[1]), .pos_sense_w_i(pos[0]),
		.direction_select_i(dir), .pwm_cycle_start_i(pwm),
		.sine_gate_hi_i(run ? SHI : 3'h0), .sine_gate_lo_i(run ? SLO : 3'h0),
		.gate_hi_o(ghi), .gate_lo_o(glo), .fault_out_o(fault), .trap_mode_o(trap)
	);

	mdp_ctrl_model u_ctrl (.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault), .run_o(run));

	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// Long enough for a latched release plus the controller's restart wait
	task automatic settle();
		repeat (20) @(posedge clk_i);
	endtask : settle

	task automatic chk_out(input logic [2:0] xh, input logic [2:0] xl, input logic xf,
			input logic xt);
		n_tests++;
		if ({ghi, glo, fault, trap} !== {xh, xl, xf, xt}) begin
			miscompares++;
			$display("mismatch at %0t: outputs %b %b %b %b", $time, ghi, glo, fault, trap);
		end
	endtask : chk_out

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk_i);
		psel   <= 1'h1;
		pen    <= 1'h0;
		pwr    <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk_i);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rd  = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen  <= 1'h0;
	endtask : apb

	// Lock in, check the hold without the release level, then release
	task automatic lock_case(input int k, input logic [2:0] xh, input logic [2:0] xl,
			input logic xf);
		lows[k] <= 1'h1;
		oks[k]  <= 1'h0;
		settle();
		chk_out(xh, xl, xf, 1'h0);
		lows[k] <= 1'h0;
		settle();
		chk_out(xh, xl, xf, 1'h0);
		oks[k] <= 1'h1;
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test lockout %0d done", k);
	endtask : lock_case

	task automatic step(input logic [2:0] code);
		pos <= code;
		settle();
	endtask : step

	// Watchdog cuts a hang short
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		apb(1'h0, CTRL_OFS, 32'h0);
		chk_word(rd, 32'h3);
		apb(1'h0, 8'h0c, 32'h0);
		chk_word({rd[30:0], err}, 32'h1);
		apb(1'h1, CTRL_OFS, 32'h0);
		settle();
		chk_out(3'h0, 3'h0, 1'h0, 1'h0);
		apb(1'h1, CTRL_OFS, 32'h2);
		apb(1'h0, CTRL_OFS, 32'h0);
		chk_word(rd, 32'h2);
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test registers done");
		step(3'h0);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		step(3'h7);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		step(3'h5);
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test position code done");
		lock_case(0, 3'h0, 3'h0, 1'h1);
		lock_case(1, 3'h0, SLO, 1'h0);
		lock_case(2, 3'h0, 3'h0, 1'h0);
		lock_case(3, 3'h0, 3'h0, 1'h1);
		lim <= 1'h1;
		repeat (40) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h0, 1'h0);
		lim <= 1'h0;
		settle();
		chk_out(3'h0, 3'h0, 1'h0, 1'h0);
		pwm <= 1'h1;
		@(posedge clk_i);
		pwm <= 1'h0;
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test current limit done");
		trip <= 1'h1;
		repeat (5) @(posedge clk_i);
		trip <= 1'h0;
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		trip <= 1'h1;
		repeat (20) @(posedge clk_i);
		trip <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		repeat (15) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		repeat (40) @(posedge clk_i);
		chk_out(SHI, SLO, 1'h0, 1'h0);
		open <= 1'h1;
		repeat (3) @(posedge clk_i);
		open <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		repeat (60) @(posedge clk_i);
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test overcurrent done");
		step(3'h1);
		chk_out(3'h1, 3'h2, 1'h1, 1'h1);
		apb(1'h0, POS_OFS, 32'h0);
		chk_word({err, rd[30:0]}, (32'h1 << POS_REV_ROT) | (32'h1 << POS_CODE));
		apb(1'h0, STATUS_OFS, 32'h0);
		chk_word({err, rd[30:0]}, (32'h1 << ST_OPPOSITE) | (32'h1 << ST_FAULT));
		step(3'h3);
		chk_out(3'h1, 3'h4, 1'h1, 1'h1);
		dir <= 1'h1;
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		step(3'h1);
		chk_out(3'h2, 3'h1, 1'h1, 1'h1);
		step(3'h5);
		chk_out(3'h2, 3'h4, 1'h1, 1'h1);
		dir <= 1'h0;
		settle();
		chk_out(SHI, SLO, 1'h0, 1'h0);
		$display("test rotation done");
		apb(1'h1, CTRL_OFS, 32'h3);
		pos <= 3'h4;
		repeat (50) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		repeat (10) @(posedge clk_i);
		pos <= 3'h6;
		repeat (5) @(posedge clk_i);
		chk_out(3'h0, 3'h0, 1'h1, 1'h0);
		repeat (30) @(posedge clk_i);
		chk_out(SHI, SLO, 1'h0, 1'h0);
		apb(1'h1, CTRL_OFS, 32'h2);
		$display("test stall guard done");
		stop_test();
	end
endmodule : mdp_supervisor_bench
